// File: core/res_port_pkg.sv
package res_port_pkg;

   // Synchronised pin vector layout
   localparam int PIN_W = 11;
   localparam int IX_CS = 0;
   localparam int IX_RD = 1;
   localparam int IX_WR = 2;
   localparam int IX_SCLK = 3;
   localparam int IX_SDI = 4;
   localparam int IX_SAMPLE = 5;
   localparam int IX_SEL = 6;
   localparam int IX_MLO = 7;
   localparam int IX_MHI = 8;
   localparam int IX_RLO = 9;
   localparam int IX_RHI = 10;
   // Strobes idle high, parallel interface chosen at reset
   localparam logic [PIN_W-1:0] PIN_RST = 11'h067;

   // Data line positions
   localparam int DATA_W = 16;
   localparam int FAULT_W = 8;
   localparam int SHIFT_W = DATA_W + FAULT_W;
   localparam int BYTE_W = 8;
   localparam int SDO_BIT = 15;
   localparam int SDI_BIT = 14;
   localparam int SCLK_BIT = 13;

   // Serial input byte length in bits
   localparam logic [3:0] CFG_BITS = 4'h8;
   localparam logic [3:0] CFG_LAST_BIT = 4'h7;

   // Output reset values and full drive enable
   localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
   localparam logic [FAULT_W-1:0] FAULT_RST = 8'h00;
   localparam logic [DATA_W-1:0] OE_ALL = 16'hffff;

   // Mode select decode {hi, lo}
   typedef enum logic [1:0] {
      MODE_POSITION = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_VELOCITY = 2'h2,
      MODE_CONFIG = 2'h3
   } mode_t;

endpackage

// File: core/resolver_converter_host_port.sv
`timescale 1ns/1ps
// Functional notes
// - Ignore interface unless chip select is low
// - Read strobe frames and enables parallel outputs
// - Drive parallel lines only while select, read low
// - Accept low byte while select, write low
// - Write strobe frames and enables serial link
// - Sample fall copies position and velocity
// - Sample fall refreshes fault register
// - Top pin is serial out, rising shift
// - Second pin is serial in, falling capture
// - Select low means serial, high parallel
// - Serial input taken only while both low
// - Two pins set conversion resolution
// - Mode selects choose item or configuration
// - Tracking loss drives output low, unlatched
module resolver_converter_host_port
   import res_port_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic chip_select_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_frame_strobe_n_i,
   input wire logic interface_select_i,
   input wire logic sample_n_i,
   input wire logic mode_select_lo_i,
   input wire logic mode_select_hi_i,
   input wire logic resolution_select_lo_i,
   input wire logic resolution_select_hi_i,
   input wire logic [DATA_W-1:0] parallel_data_lines_i,
   output logic [DATA_W-1:0] parallel_data_lines_o,
   output logic [DATA_W-1:0] parallel_data_lines_oe_o,
   input wire logic [DATA_W-1:0] position_i,
   input wire logic [DATA_W-1:0] velocity_i,
   input wire logic [FAULT_W-1:0] fault_i,
   input wire logic tracking_fault_i,
   output logic tracking_lost_n_o,
   output logic [1:0] resolution_o,
   output logic cfg_valid_o,
   output logic [BYTE_W-1:0] cfg_data_o,
   input wire logic cfg_ready_i,
   output logic write_ready_o
);

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [BYTE_W-1:0] d1;
      logic [BYTE_W-1:0] d2;
      logic [DATA_W-1:0] pos;
      logic [DATA_W-1:0] vel;
      logic [FAULT_W-1:0] flt;
      logic [SHIFT_W-1:0] sh;
      logic [BYTE_W-1:0] rx;
      logic [3:0] bitcnt;
      logic [BYTE_W-1:0] hold;
      logic [BYTE_W-1:0] cfg_last;
      logic [DATA_W-1:0] par_word;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] doe;
      logic lot_n;
      logic [1:0] res;
      logic hv;
      logic [BYTE_W-1:0] hd;
      logic tv;
      logic [BYTE_W-1:0] td;
      logic wrdy;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   // Picks the readable item for the current mode selects
   function automatic logic [DATA_W-1:0] sel_word(
      input logic [1:0] mode,
      input logic [DATA_W-1:0] pos,
      input logic [DATA_W-1:0] vel,
      input logic [BYTE_W-1:0] cfg
   );
      logic [DATA_W-1:0] w;
      w = WORD_RST;
      case (mode_t'(mode))
         MODE_POSITION: w = pos;
         MODE_VELOCITY: w = vel;
         MODE_CONFIG: w = {cfg, {(DATA_W-BYTE_W){1'b0}}};
         default: w = WORD_RST;
      endcase
      return w;
   endfunction

   // Decoded views of the synchronised pins
   logic cs_act;
   logic serial_mode;
   logic frame_act;
   logic rd_fall;
   logic wr_fall;
   logic wr_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic sample_fall;
   logic [1:0] mode_now;
   logic cfg_mode;
   logic pop;
   logic push;
   logic [BYTE_W-1:0] push_byte;

   always_comb begin
      cs_act = !st_r.s2[IX_CS];
      serial_mode = !st_r.s2[IX_SEL];
      frame_act = cs_act && serial_mode && !st_r.s2[IX_WR];
      rd_fall = !st_r.s2[IX_RD] && st_r.s3[IX_RD];
      wr_fall = !st_r.s2[IX_WR] && st_r.s3[IX_WR];
      wr_rise = st_r.s2[IX_WR] && !st_r.s3[IX_WR];
      sclk_rise = st_r.s2[IX_SCLK] && !st_r.s3[IX_SCLK];
      sclk_fall = !st_r.s2[IX_SCLK] && st_r.s3[IX_SCLK];
      sample_fall = !st_r.s2[IX_SAMPLE] && st_r.s3[IX_SAMPLE];
      mode_now = {st_r.s2[IX_MHI], st_r.s2[IX_MLO]};
      cfg_mode = (mode_t'(mode_now) == MODE_CONFIG);
   end

   // Next state of the whole port
   always_comb begin
      st_nxt = st_r;
      push = 1'b0;
      push_byte = st_r.hold;
      // Two-stage synchronisers, third stage for edge finding
      st_nxt.s1 = {resolution_select_hi_i, resolution_select_lo_i,
         mode_select_hi_i, mode_select_lo_i, interface_select_i,
         sample_n_i, parallel_data_lines_i[SDI_BIT],
         parallel_data_lines_i[SCLK_BIT], write_frame_strobe_n_i,
         read_strobe_n_i, chip_select_n_i};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.d1 = parallel_data_lines_i[BYTE_W-1:0];
      st_nxt.d2 = st_r.d1;
      // Resolution pins and tracking flag follow without latching
      st_nxt.res = {st_r.s2[IX_RHI], st_r.s2[IX_RLO]};
      st_nxt.lot_n = !tracking_fault_i;

      // Sample falling edge snapshots the integrators and faults
      if (sample_fall) begin
         st_nxt.pos = position_i;
         st_nxt.vel = velocity_i;
         st_nxt.flt = fault_i;
      end

      // Parallel read: strobe fall latches the word for output
      if (!serial_mode && cs_act && rd_fall) begin
         st_nxt.par_word = sel_word(mode_now, st_r.pos, st_r.vel,
            st_r.cfg_last);
      end

      // Parallel write: low byte held while both strobes are low
      if (!serial_mode && cs_act && !st_r.s2[IX_WR]) begin
         st_nxt.hold = st_r.d2;
      end
      if (!serial_mode && cs_act && wr_rise && cfg_mode) begin
         push = 1'b1;
      end

      // Serial frame: mode and word fixed at the frame start
      if (frame_act && wr_fall) begin
         st_nxt.sh = {sel_word(mode_now, st_r.pos, st_r.vel,
            st_r.cfg_last), st_r.flt};
      end else if (frame_act && sclk_rise) begin
         st_nxt.sh = {st_r.sh[SHIFT_W-2:0], 1'b0};
      end

      // Serial input captured on falling clock edges in a frame
      if (!frame_act) begin
         st_nxt.bitcnt = 4'h0;
      end else if (sclk_fall && st_r.bitcnt != CFG_BITS) begin
         st_nxt.rx = {st_r.rx[BYTE_W-2:0], st_r.s2[IX_SDI]};
         st_nxt.bitcnt = st_r.bitcnt + 4'h1;
         if (st_r.bitcnt == CFG_LAST_BIT && cfg_mode) begin
            push = 1'b1;
            push_byte = {st_r.rx[BYTE_W-2:0], st_r.s2[IX_SDI]};
         end
      end

      // Two-entry buffer toward the configuration logic
      pop = st_r.hv && cfg_ready_i;
      if (pop) begin
         st_nxt.hv = st_r.tv;
         st_nxt.hd = st_r.td;
         st_nxt.tv = 1'b0;
      end
      if (push && !st_r.tv) begin
         st_nxt.cfg_last = push_byte;
         if (!st_nxt.hv) begin
            st_nxt.hv = 1'b1;
            st_nxt.hd = push_byte;
         end else begin
            st_nxt.tv = 1'b1;
            st_nxt.td = push_byte;
         end
      end
      st_nxt.wrdy = !st_nxt.tv;
      // Pin drive: serial out on the top line, or the parallel word
      st_nxt.doe = WORD_RST;
      st_nxt.dout = WORD_RST;
      if (frame_act) begin
         st_nxt.doe[SDO_BIT] = 1'b1;
         st_nxt.dout[SDO_BIT] = st_nxt.sh[SHIFT_W-1];
      end else if (!serial_mode && cs_act && !st_r.s2[IX_RD]) begin
         st_nxt.doe = OE_ALL;
         st_nxt.dout = st_nxt.par_word;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
         st_r.s1 <= PIN_RST;
         st_r.s2 <= PIN_RST;
         st_r.s3 <= PIN_RST;
         st_r.lot_n <= 1'b1;
         st_r.wrdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   always_comb begin
      parallel_data_lines_o = st_r.dout;
      parallel_data_lines_oe_o = st_r.doe;
      tracking_lost_n_o = st_r.lot_n;
      resolution_o = st_r.res;
      cfg_valid_o = st_r.hv;
      cfg_data_o = st_r.hd;
      write_ready_o = st_r.wrdy;
   end

   // Deselected port never drives the data lines
   property p_cs_idle;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         st_r.s2[IX_CS] |=> parallel_data_lines_oe_o == WORD_RST;
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("data lines driven while deselected");

   // Parallel read drives all lines with the latched word
   property p_par_drive;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (st_r.s2[IX_SEL] && !st_r.s2[IX_CS] && !st_r.s2[IX_RD])
         |=> (parallel_data_lines_oe_o == OE_ALL)
         && (parallel_data_lines_o == st_r.par_word);
   endproperty
   a_par_drive: assert property (p_par_drive)
      else $error("parallel read not driven");

   // Read strobe edge in position mode latches the position
   property p_rd_latch;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (st_r.s2[IX_SEL] && !st_r.s2[IX_CS] && !st_r.s2[IX_RD]
         && st_r.s3[IX_RD] && !st_r.s2[IX_MHI] && !st_r.s2[IX_MLO])
         |=> st_r.par_word == $past(st_r.pos);
   endproperty
   a_rd_latch: assert property (p_rd_latch)
      else $error("position not latched on read");

   // Sample fall copies integrators and faults
   property p_sample;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (!st_r.s2[IX_SAMPLE] && st_r.s3[IX_SAMPLE])
         |=> (st_r.pos == $past(position_i))
         && (st_r.vel == $past(velocity_i));
   endproperty
   a_sample: assert property (p_sample)
      else $error("sample did not copy integrators");

   property p_fault;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (!st_r.s2[IX_SAMPLE] && st_r.s3[IX_SAMPLE])
         |=> st_r.flt == $past(fault_i);
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault register not refreshed");

   // Serial out moves one bit per rising serial clock
   property p_sdo_shift;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (frame_act && !wr_fall && sclk_rise)
         |=> parallel_data_lines_o[SDO_BIT] == $past(st_r.sh[SHIFT_W-2]);
   endproperty
   a_sdo_shift: assert property (p_sdo_shift)
      else $error("serial output not shifted");

   // Serial in captured on falling serial clock
   property p_sdi_take;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (frame_act && sclk_fall && st_r.bitcnt != CFG_BITS)
         |=> st_r.rx[0] == $past(st_r.s2[IX_SDI]);
   endproperty
   a_sdi_take: assert property (p_sdi_take)
      else $error("serial input bit not captured");

   // Outside a frame the input shifter stays still
   property p_sdi_gate;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         (st_r.s2[IX_CS] || st_r.s2[IX_WR]) |=> $stable(st_r.rx);
   endproperty
   a_sdi_gate: assert property (p_sdi_gate)
      else $error("serial input taken outside frame");

   // Serial mode frees the input and clock lines
   property p_serial_pins;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         frame_act |=> parallel_data_lines_oe_o[SDO_BIT]
         && !parallel_data_lines_oe_o[SDI_BIT]
         && !parallel_data_lines_oe_o[SCLK_BIT];
   endproperty
   a_serial_pins: assert property (p_serial_pins)
      else $error("serial pins driven wrongly");

   // Tracking output mirrors the flag one cycle later
   property p_lot;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         1'b1 |=> tracking_lost_n_o == !$past(tracking_fault_i);
   endproperty
   a_lot: assert property (p_lot)
      else $error("tracking output wrong");

   property p_res;
      @(posedge sys_clk_i) disable iff (!rstn_i)
         1'b1 |=> resolution_o == $past({st_r.s2[IX_RHI], st_r.s2[IX_RLO]});
   endproperty
   a_res: assert property (p_res)
      else $error("resolution not following pins");

endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ps
// Host side of the pins: strobes, mode lines and the serial link
module host_model
   import res_port_pkg::*;
(
   input wire logic clk_i,
   input wire logic [DATA_W-1:0] lines_i,
   input wire logic [DATA_W-1:0] oe_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic sel_o,
   output logic sample_n_o,
   output logic [1:0] mode_o,
   output logic [DATA_W-1:0] drive_o
);
   // Idle pins, parallel interface, serial clock parked low
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      sel_o = 1'b1;
      sample_n_o = 1'b1;
      mode_o = 2'h0;
      drive_o = 16'h0000;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic set_sel(input logic v);
      sel_o <= v;
      tick(6);
   endtask

   // Falling sample edge, held well past the synchroniser
   task automatic snap();
      sample_n_o <= 1'b0;
      tick(4);
      sample_n_o <= 1'b1;
      tick(4);
   endtask

   // Strobed read, word and enables taken while the strobe is held
   task automatic par_read(input logic en, input logic [1:0] m,
                           output logic [15:0] w, output logic [15:0] oe);
      cs_n_o <= ~en;
      mode_o <= m;
      tick(1);
      rd_n_o <= 1'b0;
      tick(8);
      w = lines_i;
      oe = oe_i;
      rd_n_o <= 1'b1;
      tick(1);
      cs_n_o <= 1'b1;
      tick(6);
   endtask

   // Strobed byte write; released byte lines flip so nothing lingers
   task automatic par_write(input logic [1:0] m, input logic [7:0] b);
      cs_n_o <= 1'b0;
      mode_o <= m;
      drive_o[7:0] <= b;
      tick(1);
      wr_n_o <= 1'b0;
      tick(4);
      wr_n_o <= 1'b1;
      tick(1);
      cs_n_o <= 1'b1;
      drive_o[7:0] <= ~b;
      tick(4);
   endtask

   // Framed 24 clock transfer, read strobe kept high, modes held
   task automatic ser_frame(input logic [1:0] m, input logic [7:0] din,
                            output logic [23:0] dout);
      cs_n_o <= 1'b0;
      mode_o <= m;
      tick(1);
      wr_n_o <= 1'b0;
      tick(6);
      for (int i = 0; i < 24; i++) begin
         dout[23-i] = lines_i[SDO_BIT];
         drive_o[SDI_BIT] <= (i < 8) ? din[7-i] : ~drive_o[SDI_BIT];
         drive_o[SCLK_BIT] <= 1'b1;
         tick(16);
         drive_o[SCLK_BIT] <= 1'b0;
         tick(16);
      end
      wr_n_o <= 1'b1;
      tick(1);
      cs_n_o <= 1'b1;
      tick(5);
   endtask
endmodule

// File: testbench/resolver_converter_host_port_tb.sv
`timescale 1ns/1ps
module resolver_converter_host_port_tb;
   import res_port_pkg::*;
   logic sys_clk, rstn, cs_n, rd_n, wr_n, sel, sample_n, trk, cfg_ready;
   logic res_lo, res_hi, lost_n, cfg_valid, wready;
   logic [1:0] mode, res;
   logic [15:0] drive, lines, data_o, oe, pos, vel, w, o;
   logic [7:0] fault, cfg_data;
   logic [23:0] s;
   int failures = 0;
   int n_tests = 0;

   // Master clock, 200 MHz
   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   // Pin level from both drivers
   assign lines = (oe & data_o) | (~oe & drive);

   host_model host (.clk_i(sys_clk), .lines_i(lines), .oe_i(oe),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel),
      .sample_n_o(sample_n), .mode_o(mode), .drive_o(drive));

   resolver_converter_host_port DUT (.sys_clk_i(sys_clk), .rstn_i(rstn),
      .chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
      .write_frame_strobe_n_i(wr_n), .interface_select_i(sel),
      .sample_n_i(sample_n), .mode_select_lo_i(mode[0]),
      .mode_select_hi_i(mode[1]), .resolution_select_lo_i(res_lo),
      .resolution_select_hi_i(res_hi), .parallel_data_lines_i(lines),
      .parallel_data_lines_o(data_o), .parallel_data_lines_oe_o(oe),
      .position_i(pos), .velocity_i(vel), .fault_i(fault),
      .tracking_fault_i(trk), .tracking_lost_n_o(lost_n),
      .resolution_o(res), .cfg_valid_o(cfg_valid), .cfg_data_o(cfg_data),
      .cfg_ready_i(cfg_ready), .write_ready_o(wready));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Take one byte from the buffer head
   task automatic pop(input logic [7:0] b);
      chk("cfg_valid", cfg_valid, 1);
      chk("cfg_data", cfg_data, b);
      cfg_ready <= 1'b1;
      @(posedge sys_clk);
      cfg_ready <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   // Hang guard
   initial begin
      #100000;
      failures++;
      final_report();
   end

   initial begin
      rstn = 1'b0;
      trk = 1'b0;
      cfg_ready = 1'b0;
      res_lo = 1'b0;
      res_hi = 1'b0;
      pos = 16'h0000;
      vel = 16'h0000;
      fault = 8'h00;
      repeat (3) @(posedge sys_clk);
      chk("oe_rst", oe, 0);
      chk("lost_rst", lost_n, 1);
      chk("wready_rst", wready, 1);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // Every resolution code
      for (int k = 0; k < 4; k++) begin
         {res_hi, res_lo} <= k[1:0];
         repeat (5) @(posedge sys_clk);
         chk("resolution", res, k);
      end
      // Tracking flag follows, not held
      trk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("lost_on", lost_n, 0);
      trk <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("lost_off", lost_n, 1);
      // Snapshot, then core values move on
      pos <= 16'h1234;
      vel <= 16'hbeef;
      fault <= 8'h5a;
      @(posedge sys_clk);
      host.snap();
      pos <= 16'h0f0f;
      vel <= 16'hf0f0;
      host.par_read(1, 2'h0, w, o);
      chk("pos", w, 16'h1234);
      chk("oe_rd", o, 16'hffff);
      host.par_read(1, 2'h2, w, o);
      chk("vel", w, 16'hbeef);
      host.par_read(1, 2'h1, w, o);
      chk("reserved", w, 0);
      chk("oe_idle", oe, 0);
      host.par_read(0, 2'h0, w, o);
      chk("oe_nocs", o, 0);
      // Stalled consumer: third byte finds the buffer full
      host.par_write(2'h3, 8'ha5);
      host.par_write(2'h3, 8'h3c);
      chk("wready_full", wready, 0);
      host.par_write(2'h3, 8'h77);
      pop(8'ha5);
      pop(8'h3c);
      chk("cfg_empty", cfg_valid, 0);
      chk("wready_free", wready, 1);
      host.par_write(2'h0, 8'h99);
      chk("cfg_refused", cfg_valid, 0);
      host.par_write(2'h3, 8'h42);
      pop(8'h42);
      host.par_read(1, 2'h3, w, o);
      chk("cfg_read", w, 16'h4200);
      // Serial link
      host.set_sel(1'b0);
      pos <= 16'hc3a5;
      fault <= 8'h81;
      @(posedge sys_clk);
      host.snap();
      host.ser_frame(2'h0, 8'h00, s);
      chk("ser_pos", s, {16'hc3a5, 8'h81});
      host.ser_frame(2'h3, 8'h6e, s);
      chk("ser_cfg", s, {16'h4200, 8'h81});
      pop(8'h6e);
      chk("oe_ser_idle", oe, 0);
      final_report();
   end
endmodule
